// *** smc_map.svh ***
`ifndef SMC_MAP_SVH
`define SMC_MAP_SVH
// Fixed stop period after deep standby release, in ns (typical figure)
`define SMC_STOP_TIME_NS 34000
`define SMC_CLK_PERIOD_NS 8
// Stop period in clock cycles, rounded down as a longest time
`define SMC_STOP_CYCLES (`SMC_STOP_TIME_NS / `SMC_CLK_PERIOD_NS)
`define SMC_SETTLE_SEL_W 3
`define SMC_SETTLE_W 20
// Shortest settle step is 2^10 cycles
`define SMC_SETTLE_BASE_LOG2 10
`define SMC_ZERO_SETTLE 20'h00000
`endif

// *** smc_pkg.sv ***
`default_nettype none
`include "smc_map.svh"
package smc_pkg;
   typedef enum logic [1:0] {SMC_NONE, SMC_HALT, SMC_STOP} smc_cmd_t;
   typedef struct packed {
      logic lso_stoppable;
      logic crystal_osc;
      logic [`SMC_SETTLE_SEL_W-1:0] reset_settle_sel;
   } smc_option_t;
endpackage : smc_pkg
`default_nettype wire

// *** smc_wait_counter.sv ***
`default_nettype none
`include "smc_map.svh"
module smc_wait_counter #(
   parameter int W = `SMC_SETTLE_W
) (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   // Control
   input wire logic i_load,
   input wire logic [W-1:0] i_count,
   input wire logic i_run,
   // Status
   output logic o_done
);
   logic [W-1:0] count_reg;

   // Counts down only while i_run is high
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         count_reg <= '0;
      end else if (i_load) begin
         count_reg <= i_count;
      end else if (i_run && count_reg != '0) begin
         count_reg <= count_reg - W'(1);
      end
   end

   // Pure decode of the count: the loader reacts to it, so it must not look back at i_load
   assign o_done = (count_reg == '0);
endmodule : smc_wait_counter
`default_nettype wire

// *** smc_standby_ctrl.sv ***
// Contract
// - Low-speed oscillator stop request honoured only when option allows it.
// - Running low-speed oscillator keeps running throughout deep standby.
// - Settle wait counts only after oscillation has restarted.
// - Reset settle wait comes from option byte, not software selection.
// - Pending unmasked interrupt releases light or deep standby at once.
// - Deep standby release: settle wait if crystal, then 34 us stop.
`default_nettype none
`include "smc_map.svh"
module smc_standby_ctrl
   import smc_pkg::*;
#(
   parameter int NUM_IRQ = 16,
   parameter int STOP_CYCLES = `SMC_STOP_CYCLES
) (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   // CPU core
   input wire smc_cmd_t i_cmd,
   input wire logic i_cmd_valid,
   // Interrupt flags
   input wire logic [NUM_IRQ-1:0] i_irq_req,
   input wire logic [NUM_IRQ-1:0] i_irq_mask,
   // Configuration
   input wire smc_option_t i_option,
   input wire logic [`SMC_SETTLE_SEL_W-1:0] i_osc_settle_select,
   input wire logic i_low_speed_osc_stop_request,
   input wire logic i_osc_running,
   // Clock control and status
   output logic o_cpu_clk_en,
   output logic o_sys_osc_en,
   output logic o_low_speed_osc_en,
   output logic o_halt_active,
   output logic o_stop_active,
   output logic o_wake
);
   // ==========================================================
   // Settle wait table
   // ==========================================================
   function automatic logic [`SMC_SETTLE_W-1:0] settle_cycles(input logic [`SMC_SETTLE_SEL_W-1:0] sel);
      // Power of two steps; the widest selection must still fit the counter width
      settle_cycles = `SMC_SETTLE_W'(1) << (`SMC_SETTLE_BASE_LOG2 + int'(sel));
   endfunction : settle_cycles

   // ==========================================================
   // State and helper signals
   // ==========================================================
   typedef enum logic [2:0] {
      ST_RESET_SETTLE,
      ST_RUN,
      ST_HALT,
      ST_STOP,
      ST_OSC_START,
      ST_SETTLE,
      ST_STOP_PERIOD
   } smc_state_t;
   smc_state_t state_reg;
   smc_state_t state_next;
   logic wake_any;
   logic lso_reg;
   logic wait_load;
   logic [`SMC_SETTLE_W-1:0] wait_value;
   logic wait_run;
   logic wait_done;
   logic first_reg;

   // ==========================================================
   // Wake detection
   // ==========================================================
   // unmasked pending
   assign wake_any = |(i_irq_req & ~i_irq_mask);

   // ==========================================================
   // State machine
   // ==========================================================
   always_comb begin
      state_next = state_reg;
      wait_load = 1'b0;
      wait_value = `SMC_ZERO_SETTLE;
      case (state_reg)
         ST_RESET_SETTLE: begin
            // Loaded on the first cycle out of reset, so a short reset still waits in full
            // option byte wait
            if (first_reg) begin
               wait_load = 1'b1;
               wait_value = settle_cycles(i_option.reset_settle_sel);
            end else if (wait_done) begin
               state_next = ST_RUN;
            end
         end
         ST_RUN: begin
            // Release wins over entry: a pending request turns the instruction into a no-op
            // enter standby
            if (i_cmd_valid && i_cmd == SMC_HALT && !wake_any) begin
               state_next = ST_HALT;
            end else if (i_cmd_valid && i_cmd == SMC_STOP && !wake_any) begin
               state_next = ST_STOP;
            end
         end
         ST_HALT: begin
            if (wake_any) begin
               state_next = ST_RUN;
            end
         end
         ST_STOP: begin
            if (wake_any) begin
               state_next = ST_OSC_START;
            end
         end
         ST_OSC_START: begin
            // A resonator that never starts keeps the block here; only reset leaves
            // wait for oscillation
            if (i_osc_running) begin
               wait_load = 1'b1;
               if (i_option.crystal_osc) begin
                  state_next = ST_SETTLE;
                  wait_value = settle_cycles(i_osc_settle_select);
               end else begin
                  state_next = ST_STOP_PERIOD;
                  wait_value = `SMC_SETTLE_W'(STOP_CYCLES);
               end
            end
         end
         ST_SETTLE: begin
            if (wait_done) begin
               wait_load = 1'b1;
               wait_value = `SMC_SETTLE_W'(STOP_CYCLES);
               state_next = ST_STOP_PERIOD;
            end
         end
         ST_STOP_PERIOD: begin
            if (wait_done) begin
               state_next = ST_RUN;
            end
         end
         default: begin
            // Unused encodings fall back to normal operation
            state_next = ST_RUN;
         end
      endcase
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         state_reg <= ST_RESET_SETTLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // High throughout reset and for the first cycle after it
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         first_reg <= 1'b1;
      end else begin
         first_reg <= 1'b0;
      end
   end

   // Counter holds in OSC_START: the time until oscillation is not part of any wait
   assign wait_run = (state_reg == ST_SETTLE) ||
      (state_reg == ST_STOP_PERIOD) ||
      (state_reg == ST_RESET_SETTLE);

   smc_wait_counter #(
      .W(`SMC_SETTLE_W)
   ) u_wait (
      .i_ref_clk(i_ref_clk),
      .i_sys_rst(i_sys_rst),
      .i_load(wait_load),
      .i_count(wait_value),
      .i_run(wait_run),
      .o_done(wait_done)
   );

   // ==========================================================
   // Low-speed oscillator
   // ==========================================================
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         lso_reg <= 1'b1;
      end else begin
         // Frozen while stopped: the oscillator cannot be switched off from inside the deep state
         // gated stop request; never altered while stopped
         if (state_reg != ST_STOP) begin
            lso_reg <= !(i_option.lso_stoppable && i_low_speed_osc_stop_request);
         end
      end
   end

   // ==========================================================
   // Release pulse
   // ==========================================================
   // One cycle wide, so the core can count releases without clearing anything
   // release pulse
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         o_wake <= 1'b0;
      end else begin
         o_wake <= ((state_reg == ST_HALT) || (state_reg == ST_STOP)) && wake_any;
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   // CPU and system oscillator enables decode the state, so they change on the edge that moves the state
   assign o_cpu_clk_en = (state_reg == ST_RUN);
   assign o_sys_osc_en = (state_reg != ST_STOP);
   assign o_low_speed_osc_en = lso_reg;
   assign o_halt_active = (state_reg == ST_HALT);
   assign o_stop_active = (state_reg == ST_STOP);
endmodule : smc_standby_ctrl
`default_nettype wire

// *** smc_osc_model.sv ***
`default_nettype none
// ==========
// Oscillator restart model
module smc_osc_model (
   input wire logic i_ref_clk,
   input wire logic i_osc_en,
   output logic o_running
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] start_reg = 3'h0;
   always_ff @(posedge i_ref_clk) begin
      start_reg <= i_osc_en ? {start_reg[1:0], 1'b1} : 3'h0;
   end
   assign o_running = start_reg[2];
endmodule : smc_osc_model
`default_nettype wire

// *** smc_standby_ctrl_assertions.sv ***
`default_nettype none
`include "smc_map.svh"
// ==========
// Standby checks
module smc_standby_ctrl_checker
   import smc_pkg::*;
#(parameter int NUM_IRQ = 16, parameter int STOP_CYCLES = 8) (
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire smc_cmd_t i_cmd,
   input wire logic i_cmd_valid,
   input wire logic [NUM_IRQ-1:0] i_irq_req,
   input wire logic [NUM_IRQ-1:0] i_irq_mask,
   input wire smc_option_t i_option,
   input wire logic i_osc_running,
   input wire logic o_cpu_clk_en,
   input wire logic o_sys_osc_en,
   input wire logic o_low_speed_osc_en,
   input wire logic o_halt_active,
   input wire logic o_stop_active,
   input wire logic o_wake
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_sys_rst);
   wire logic pend = |(i_irq_req & ~i_irq_mask);
   wire logic sby = o_halt_active | o_stop_active;
   a_halt_entry: assert property (i_cmd_valid && i_cmd == SMC_HALT && o_cpu_clk_en && !pend |=> o_halt_active)
      else $error("halt not entered");
   a_stop_gates: assert property (o_stop_active |-> !o_sys_osc_en && !o_cpu_clk_en)
      else $error("clocks on in stop");
   a_irq_release: assert property (sby && pend |=> !sby)
      else $error("standby kept with irq");
   a_pending_refuse: assert property (i_cmd_valid && pend && o_cpu_clk_en |=> o_cpu_clk_en)
      else $error("entry despite irq");
   a_wake_pulse: assert property (sby && pend |=> o_wake)
      else $error("no wake pulse on release");
   a_wake_quiet: assert property (!(sby && pend) |=> !o_wake)
      else $error("wake pulse without release");
   a_lso_frozen: assert property (o_stop_active && o_low_speed_osc_en |=> o_low_speed_osc_en)
      else $error("low speed osc stopped in stop");
   a_lso_locked: assert property (!i_option.lso_stoppable && o_low_speed_osc_en |=> o_low_speed_osc_en)
      else $error("low speed osc stopped");
   a_reset_settle: assert property ($fell(i_sys_rst) |-> !o_cpu_clk_en [*8])
      else $error("no reset settle");
   a_osc_first: assert property (!i_osc_running && !o_cpu_clk_en |=> !o_cpu_clk_en)
      else $error("run before oscillation");
   a_stop_time: assert property ($rose(i_osc_running) && !sby && !i_option.crystal_osc
      |-> !o_cpu_clk_en [*8] ##[1:4] o_cpu_clk_en)
      else $error("stop period wrong");
   cover property (o_halt_active ##1 !o_halt_active);
   cover property (o_stop_active ##1 !o_stop_active);
   cover property (i_cmd_valid && pend);
endmodule : smc_standby_ctrl_checker
`default_nettype wire

// *** smc_standby_ctrl_bench.sv ***
`default_nettype none
// ==========
// Standby bench
module smc_standby_ctrl_bench;
   import smc_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_ref_clk = 1'b0, i_sys_rst = 1'b1, i_cmd_valid = 1'b0, i_low_speed_osc_stop_request = 1'b0;
   smc_cmd_t i_cmd = SMC_NONE;
   logic [15:0] i_irq_req = 16'h0000, i_irq_mask = 16'hFFFF;
   smc_option_t i_option = '0;
   logic [2:0] i_osc_settle_select = 3'h7;
   logic i_osc_running, o_cpu_clk_en, o_sys_osc_en, o_low_speed_osc_en, o_halt_active, o_stop_active, o_wake;
   int fail_count = 0, total_checks = 0;
   always #4 i_ref_clk = ~i_ref_clk;
   smc_osc_model smc_osc_model_inst (.i_ref_clk(i_ref_clk), .i_osc_en(o_sys_osc_en), .o_running(i_osc_running));
   smc_standby_ctrl #(.NUM_IRQ(16), .STOP_CYCLES(8)) smc_standby_ctrl_inst (.i_ref_clk(i_ref_clk),
      .i_sys_rst(i_sys_rst), .i_cmd(i_cmd), .i_cmd_valid(i_cmd_valid), .i_irq_req(i_irq_req),
      .i_irq_mask(i_irq_mask), .i_option(i_option), .i_osc_settle_select(i_osc_settle_select),
      .i_low_speed_osc_stop_request(i_low_speed_osc_stop_request), .i_osc_running(i_osc_running),
      .o_cpu_clk_en(o_cpu_clk_en), .o_sys_osc_en(o_sys_osc_en), .o_low_speed_osc_en(o_low_speed_osc_en),
      .o_halt_active(o_halt_active), .o_stop_active(o_stop_active), .o_wake(o_wake));
   task automatic print_verdict;
      $display("checks %0d failures %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : print_verdict
   task automatic chk(input logic ok, input string m);
      total_checks++;
      if (ok !== 1'b1) begin
         fail_count++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(negedge i_ref_clk);
   endtask : cyc
   task automatic run_wait(input int lo, input int hi);
      int n;
      n = 0;
      while (o_cpu_clk_en !== 1'b1 && n < hi) begin
         cyc(1);
         n++;
      end
      chk(n >= lo && n < hi, "wait length");
      if (n >= hi) print_verdict();
   endtask : run_wait
   task automatic issue(input smc_cmd_t c);
      i_cmd = c;
      i_cmd_valid = 1'b1;
      cyc(1);
      i_cmd_valid = 1'b0;
   endtask : issue
   task automatic t_reset(input logic [2:0] sel);
      i_sys_rst = 1'b1;
      i_option.reset_settle_sel = sel;
      cyc(20);
      i_sys_rst = 1'b0;
      run_wait(2 ** (sel + 10), 2 ** (sel + 10) + 8);
   endtask : t_reset
   task automatic t_halt;
      issue(SMC_HALT);
      chk(o_halt_active && !o_cpu_clk_en, "halt entry");
      i_irq_req = 16'h8000;
      i_irq_mask = 16'h8000;
      cyc(5);
      chk(o_halt_active, "masked irq woke");
      i_irq_mask = 16'h0000;
      cyc(1);
      chk(!o_halt_active, "halt kept");
      chk(o_wake, "no halt wake pulse");
      i_irq_req = 16'h0000;
      cyc(1);
      chk(!o_wake, "wake pulse too long");
      run_wait(0, 3);
      i_irq_req = 16'h0001;
      issue(SMC_STOP);
      chk(o_cpu_clk_en && !o_stop_active, "entry with pending irq");
      i_irq_req = 16'h0000;
   endtask : t_halt
   task automatic t_stop(input logic xtal);
      i_option.crystal_osc = xtal;
      i_osc_settle_select = 3'h0;
      issue(SMC_STOP);
      cyc(10);
      chk(o_stop_active && !o_sys_osc_en && !o_cpu_clk_en, "stop entry");
      i_irq_req = 16'h0002;
      cyc(1);
      i_irq_req = 16'h0000;
      chk(o_wake, "no stop wake pulse");
      run_wait(11 + (xtal ? 1024 : 0), 16 + (xtal ? 1024 : 0));
   endtask : t_stop
   task automatic t_lso;
      i_low_speed_osc_stop_request = 1'b1;
      cyc(3);
      chk(o_low_speed_osc_en, "request not refused");
      issue(SMC_STOP);
      i_option.lso_stoppable = 1'b1;
      cyc(4);
      chk(o_low_speed_osc_en, "stopped in stop");
      i_irq_req = 16'h0004;
      cyc(1);
      i_irq_req = 16'h0000;
      run_wait(11, 16);
      cyc(3);
      chk(!o_low_speed_osc_en, "request ignored");
   endtask : t_lso
   initial begin
      t_reset(3'h0);
      t_halt();
      t_stop(1'b1);
      t_stop(1'b0);
      t_lso();
      t_reset(3'h1);
      print_verdict();
   end
endmodule : smc_standby_ctrl_bench
bind smc_standby_ctrl smc_standby_ctrl_checker #(.NUM_IRQ(NUM_IRQ), .STOP_CYCLES(STOP_CYCLES)) chk_inst (.*);
`default_nettype wire
